// [rtl/rgb_pwm_led_controller.sv]
// rgb pwm led controller: serial command link, pwm channels, ahb-lite status
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - three independent pwm channels, thirty-two brightness steps each, one per colour
// - duty code n gives an active time of (n+1)/32 of the period
// - each open-drain output carries its channel's pwm waveform as configured
// - oscillator starts and stops by command and stays stopped while off
// - stopping the oscillator freezes outputs; host turns outputs off first
// - data line is sampled into the shift register on rising shift clock
// - rising select hands the eight shifted bits to the decoder for execution
// - opcodes 000, 001, 010 load a five-bit duty for channel one, two, three
// - opcode 011 sets rate select, oscillator on and three output enables
// - opcodes 100, 101, 110 set channel phase from bits 1..0
// - duty, rate and phase apply after about 128 oscillator ticks
// - reset pin is active low and initialises settings and counters while low, not the shift register or divisor
// - reset clears rate, oscillator, enables, phases and duties; pulse at least 1us
// - with more than eight bits shifted, only the last eight execute
// - shifting ignores select; select only times the hand-over
module rgb_pwm_led_controller
	import rgb_pwm_pkg::*;
#(
	parameter int unsigned OSC_DIV_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic reset_n_pin_i,
	input wire logic select_n_pin_i,
	input wire logic shift_clk_pin_i,
	input wire logic data_pin_i,
	output logic sink_out_one_o,
	output logic sink_out_one_oe_o,
	output logic sink_out_two_o,
	output logic sink_out_two_oe_o,
	output logic sink_out_three_o,
	output logic sink_out_three_oe_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);

	// ==========================================================
	// elaboration check
	if (OSC_DIV_W < 2 || OSC_DIV_W > 16) begin : g_bad_width
		$error("OSC_DIV_W must lie between 2 and 16");
	end

	// ==========================================================
	// pin synchronisers
	logic [2:0] sclk_s_r;
	logic [2:0] sel_s_r;
	logic [1:0] dat_s_r;
	logic [1:0] rstp_s_r;
	logic sclk_rise;
	logic sel_rise;
	logic settings_rst;

	// two flops per pin, third stage only for edge detection
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sclk_s_r <= 3'h0;
			sel_s_r <= 3'h7;
			dat_s_r <= 2'h0;
			rstp_s_r <= 2'h3;
		end else begin
			sclk_s_r <= {sclk_s_r[1:0], shift_clk_pin_i};
			sel_s_r <= {sel_s_r[1:0], select_n_pin_i};
			dat_s_r <= {dat_s_r[0], data_pin_i};
			rstp_s_r <= {rstp_s_r[0], reset_n_pin_i};
		end
	end

	assign sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
	assign sel_rise = sel_s_r[1] && !sel_s_r[2];
	assign settings_rst = !rst_n_i || !rstp_s_r[1];

	// ==========================================================
	// serial shift register
	logic [CMD_W-1:0] shift_r;

	// data and clock share sync depth, so their alignment survives
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			shift_r <= 8'h00;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[CMD_W-2:0], dat_s_r[1]};
		end
	end

	// ==========================================================
	// command decode: commanded settings
	logic [2:0] op;
	logic cmd_exec;
	logic delayed_op;
	logic [DUTY_W-1:0] duty_cmd_r [3];
	logic [1:0] phase_cmd_r [3];
	logic rate_cmd_r;
	logic osc_on_r;
	logic [2:0] en_r;

	assign op = shift_r[CMD_W-1:OP_LSB];
	assign cmd_exec = sel_rise && !settings_rst;
	assign delayed_op = (op != OP_TEST); // test opcode is dropped

	always_ff @(posedge ref_clk_i) begin
		if (settings_rst) begin
			for (int c = 0; c < 3; c++) begin
				duty_cmd_r[c] <= DUTY_RST;
				phase_cmd_r[c] <= PHASE_RST;
			end
			rate_cmd_r <= RATE_RST;
			osc_on_r <= OSC_RST;
			en_r <= EN_RST;
		end else if (cmd_exec) begin
			case (op)
				OP_DUTY_ONE: duty_cmd_r[0] <= shift_r[DUTY_W-1:0];
				OP_DUTY_TWO: duty_cmd_r[1] <= shift_r[DUTY_W-1:0];
				OP_DUTY_THREE: duty_cmd_r[2] <= shift_r[DUTY_W-1:0];
				OP_CONFIG: begin
					rate_cmd_r <= shift_r[CFG_RATE_BIT];
					osc_on_r <= shift_r[CFG_OSC_BIT];
					// command bit 2 is channel one, kept at index 0 like the channels
					en_r <= {shift_r[CFG_EN_ONE_BIT-2], shift_r[CFG_EN_ONE_BIT-1], shift_r[CFG_EN_ONE_BIT]};
				end
				OP_PHASE_ONE: phase_cmd_r[0] <= shift_r[1:0];
				OP_PHASE_TWO: phase_cmd_r[1] <= shift_r[1:0];
				OP_PHASE_THREE: phase_cmd_r[2] <= shift_r[1:0];
				default: ; // test opcode ignored, release word included
			endcase
		end
	end

	// ==========================================================
	// oscillator model: divider from ref clock, stops when commanded off
	logic [OSC_DIV_W-1:0] osc_div_r;
	logic [OSC_DIV_W-1:0] div_cnt_r;
	logic osc_tick;

	// divisor 0 and 1 both tick every cycle
	assign osc_tick = osc_on_r && ({1'b0, div_cnt_r} + 1'b1 >= {1'b0, osc_div_r});

	always_ff @(posedge ref_clk_i) begin
		if (settings_rst) begin
			div_cnt_r <= '0;
		end else if (osc_tick) begin
			div_cnt_r <= '0;
		end else if (osc_on_r) begin
			div_cnt_r <= div_cnt_r + 1'b1;
		end
	end

	// ==========================================================
	// execution delay: applied settings trail the commanded ones
	logic busy_r;
	logic [7:0] dly_cnt_r;
	logic apply_now;
	logic [DUTY_W-1:0] duty_r [3];
	logic [1:0] phase_r [3];
	logic rate_r;

	assign apply_now = busy_r && osc_tick && (dly_cnt_r == 8'(EXEC_DELAY_TICKS - 1));

	// a new command other than the test opcode restarts the wait; ticks only count while the oscillator runs
	always_ff @(posedge ref_clk_i) begin
		if (settings_rst) begin
			busy_r <= 1'b0;
			dly_cnt_r <= 8'h00;
		end else if (cmd_exec && delayed_op) begin
			busy_r <= 1'b1;
			dly_cnt_r <= 8'h00;
		end else if (apply_now) begin
			busy_r <= 1'b0;
		end else if (busy_r && osc_tick) begin
			dly_cnt_r <= dly_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (settings_rst) begin
			for (int c = 0; c < 3; c++) begin
				duty_r[c] <= DUTY_RST;
				phase_r[c] <= PHASE_RST;
			end
			rate_r <= RATE_RST;
		end else if (apply_now) begin
			duty_r <= duty_cmd_r;
			phase_r <= phase_cmd_r;
			rate_r <= rate_cmd_r;
		end
	end

	// ==========================================================
	// step prescaler and shared pwm counter
	logic [1:0] pre_cnt_r;
	logic step_tick;
	logic [DUTY_W-1:0] pwm_cnt_r;

	assign step_tick = osc_tick && (pre_cnt_r >= (rate_r ? STEP_DIV_RATE1 : STEP_DIV_RATE0));

	// counter freezes with the oscillator, so outputs hold their phase
	always_ff @(posedge ref_clk_i) begin
		if (settings_rst) begin
			pre_cnt_r <= 2'h0;
			pwm_cnt_r <= '0;
		end else if (step_tick) begin
			pre_cnt_r <= 2'h0;
			pwm_cnt_r <= pwm_cnt_r + 1'b1;
		end else if (osc_tick) begin
			pre_cnt_r <= pre_cnt_r + 2'h1;
		end
	end

	// ==========================================================
	// channels
	logic [2:0] drive_r;

	for (genvar c = 0; c < 3; c++) begin : g_ch
		logic [DUTY_W-1:0] pos;
		// a nonzero phase code delays the waveform by its offset of 4, 8 or 16 steps
		assign pos = pwm_cnt_r - phase_offset(phase_r[c]);
		always_ff @(posedge ref_clk_i) begin
			if (settings_rst) begin
				drive_r[c] <= 1'b0;
			end else begin
				drive_r[c] <= en_r[c] && ({1'b0, pos} < {1'b0, duty_r[c]} + 6'h01);
			end
		end

		a_full_duty: assert property (@(posedge ref_clk_i) disable iff (settings_rst)
			(en_r[c] && duty_r[c] == 5'h1F) |=> drive_r[c])
			else $error("full duty channel not driving");
		a_disabled_off: assert property (@(posedge ref_clk_i) disable iff (settings_rst)
			!en_r[c] |=> !drive_r[c])
			else $error("disabled channel is driving");
	end

	// open drain: sink low while driving, float otherwise
	assign sink_out_one_o = 1'b0;
	assign sink_out_two_o = 1'b0;
	assign sink_out_three_o = 1'b0;
	assign sink_out_one_oe_o = drive_r[0];
	assign sink_out_two_oe_o = drive_r[1];
	assign sink_out_three_oe_o = drive_r[2];

	// ==========================================================
	// ahb-lite slave, zero wait states, low address byte decoded
	logic acc_ok;
	logic wr_pend_r;
	logic [7:0] addr_r;
	logic [31:0] status_word;
	logic [31:0] hrdata_r;

	assign acc_ok = hsel_i && htrans_i[1] && hready_i;

	always_comb begin
		status_word = 32'h0000_0000;
		for (int c = 0; c < 3; c++) begin
			status_word[c*DUTY_W +: DUTY_W] = duty_r[c];
			status_word[ST_PHASE_LSB + c*2 +: 2] = phase_r[c];
		end
		status_word[ST_EN_LSB +: 3] = en_r;
		status_word[ST_OSC_BIT] = osc_on_r;
		status_word[ST_RATE_BIT] = rate_r;
		status_word[ST_BUSY_BIT] = busy_r;
	end

	// address phase capture; only word writes are honoured
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc_ok && hwrite_i && (hsize_i == HSIZE_WORD);
			if (acc_ok) begin
				addr_r <= haddr_i[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			osc_div_r <= OSC_DIV_W'(OSC_DIV_RST);
		end else if (wr_pend_r && addr_r == OSC_DIV_OFS) begin
			osc_div_r <= hwdata_i[OSC_DIV_W-1:0];
		end
	end

	// read data registered at the address phase; unmapped reads zero
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			hrdata_r <= 32'h0000_0000;
		end else if (acc_ok && !hwrite_i) begin
			case (haddr_i[7:0])
				OSC_DIV_OFS: hrdata_r <= 32'(osc_div_r);
				STATUS_OFS: hrdata_r <= status_word;
				default: hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign hrdata_o = hrdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (settings_rst);

	a_shift_in: assert property (sclk_rise
		|=> shift_r == {$past(shift_r[6:0]), $past(dat_s_r[1])})
		else $error("shift register missed a bit");
	a_duty_load: assert property ((cmd_exec && op == OP_DUTY_TWO)
		|=> duty_cmd_r[1] == $past(shift_r[4:0]))
		else $error("duty command not loaded");
	a_cfg_load: assert property ((cmd_exec && op == OP_CONFIG)
		|=> (en_r == {$past(shift_r[0]), $past(shift_r[1]), $past(shift_r[2])})
		&& (osc_on_r == $past(shift_r[3])))
		else $error("config command not loaded");
	a_phase_load: assert property ((cmd_exec && op == OP_PHASE_THREE)
		|=> phase_cmd_r[2] == $past(shift_r[1:0]))
		else $error("phase command not loaded");
	a_osc_stopped: assert property (!osc_on_r |-> !osc_tick && !step_tick)
		else $error("oscillator ticks while off");
	a_hold_frozen: assert property (!osc_on_r ##1 !osc_on_r |-> $stable(pwm_cnt_r))
		else $error("pwm counter moved while oscillator off");
	a_exec_wait: assert property ((cmd_exec && delayed_op) |=> busy_r ##1
		($stable(duty_r[0]) && $stable(duty_r[1]) && $stable(duty_r[2])))
		else $error("setting applied without delay");
	a_reset_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!rstp_s_r[1] |=> (en_r == 3'h0) && !osc_on_r && !rate_r && (duty_r[0] == 5'h00))
		else $error("reset pin did not clear settings");

	c_config: cover property (cmd_exec && op == OP_CONFIG && shift_r[3]);
	c_apply: cover property (apply_now);
	c_wrap: cover property (step_tick && pwm_cnt_r == 5'h1F);
	c_test_cmd: cover property (cmd_exec && op == OP_TEST);

endmodule : rgb_pwm_led_controller

`default_nettype wire

// [rtl/rgb_pwm_pkg.sv]
// constants shared by the rgb pwm led controller
package rgb_pwm_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_FREQ_HZ = 50_000_000;
	localparam int unsigned EXEC_DELAY_TICKS = 128; // oscillator ticks before settings apply
	localparam logic [1:0] STEP_DIV_RATE0 = 2'h1; // (fosc/2)/32: two ticks per step, minus one
	localparam logic [1:0] STEP_DIV_RATE1 = 2'h3; // (fosc/2)/64: four ticks per step, minus one

	// ==========================================================
	// serial command layout
	localparam int unsigned CMD_W = 8;
	localparam int unsigned DUTY_W = 5;
	localparam int unsigned OP_LSB = 5;
	localparam logic [2:0] OP_DUTY_ONE = 3'h0;
	localparam logic [2:0] OP_DUTY_TWO = 3'h1;
	localparam logic [2:0] OP_DUTY_THREE = 3'h2;
	localparam logic [2:0] OP_CONFIG = 3'h3;
	localparam logic [2:0] OP_PHASE_ONE = 3'h4;
	localparam logic [2:0] OP_PHASE_TWO = 3'h5;
	localparam logic [2:0] OP_PHASE_THREE = 3'h6;
	localparam logic [2:0] OP_TEST = 3'h7;
	localparam int unsigned CFG_RATE_BIT = 4;
	localparam int unsigned CFG_OSC_BIT = 3;
	localparam int unsigned CFG_EN_ONE_BIT = 2; // bits 2,1,0 enable outputs one,two,three

	// ==========================================================
	// reset values of settings
	localparam logic [4:0] DUTY_RST = 5'h00;
	localparam logic [1:0] PHASE_RST = 2'h0;
	localparam logic RATE_RST = 1'b0;
	localparam logic OSC_RST = 1'b0;
	localparam logic [2:0] EN_RST = 3'h0;

	// ==========================================================
	// bus registers
	localparam logic [7:0] OSC_DIV_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [15:0] OSC_DIV_RST = 16'h0010;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int unsigned ST_PHASE_LSB = 15;
	localparam int unsigned ST_EN_LSB = 21;
	localparam int unsigned ST_OSC_BIT = 24;
	localparam int unsigned ST_RATE_BIT = 25;
	localparam int unsigned ST_BUSY_BIT = 26;

	// phase code to step offset: none, 4, 8, 16
	function automatic logic [4:0] phase_offset(input logic [1:0] code);
		case (code)
			2'h1: phase_offset = 5'h04;
			2'h2: phase_offset = 5'h08;
			2'h3: phase_offset = 5'h10;
			default: phase_offset = 5'h00;
		endcase
	endfunction : phase_offset

endpackage : rgb_pwm_pkg

// [test/serial_host_model.sv]
// host model driving the three-wire serial command link
`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
	input wire logic clk_i,
	output logic select_n_o,
	output logic shift_clk_o,
	output logic data_o
);
	// idle pins: select high, shift clock parked low
	initial begin
		select_n_o = 1'b1;
		shift_clk_o = 1'b0;
		data_o = 1'b0;
	end

	// ==========================================================
	// frame sender: n bits msb first, four ref cycles per half clock
	task automatic send(input logic [15:0] w, input int n, input logic sel_hi);
		if (!sel_hi) select_n_o <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			data_o <= w[i];
			repeat (4) @(posedge clk_i);
			shift_clk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			shift_clk_o <= 1'b0;
		end
		data_o <= ~w[0]; // released line must not keep the last bit
		repeat (4) @(posedge clk_i);
		select_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		select_n_o <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask : send
endmodule : serial_host_model

`default_nettype wire

// [test/rgb_pwm_led_controller_bench.sv]
// self-checking bench for the rgb pwm led controller
`timescale 1ns/1ns
`default_nettype none

module rgb_pwm_led_controller_bench;
	import rgb_pwm_pkg::*;
	logic clk, rst_n, pin_rst_n, sel_n, sclk, sdata, oe1, oe2, oe3, s1, s2, s3;
	logic hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, seed, rd;
	logic [7:0] c1, c2, c3, ex;
	logic [4:0] e_duty [3];
	logic [1:0] e_ph [3];
	logic [2:0] e_en;
	logic e_osc, e_rate;
	int failures, samples_checked;

	rgb_pwm_led_controller rgb_pwm_led_controller_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
		.reset_n_pin_i(pin_rst_n), .select_n_pin_i(sel_n), .shift_clk_pin_i(sclk),
		.data_pin_i(sdata), .sink_out_one_o(s1), .sink_out_one_oe_o(oe1), .sink_out_two_o(s2),
		.sink_out_two_oe_o(oe2), .sink_out_three_o(s3), .sink_out_three_oe_o(oe3),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
		.hresp_o(hresp));
	serial_host_model serial_host_model_inst (.clk_i(clk), .select_n_o(sel_n),
		.shift_clk_o(sclk), .data_o(sdata));

	// 50 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================================
	// expectation helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic logic [31:0] exp_status();
		return {6'h00, e_rate, e_osc, e_en[0], e_en[1], e_en[2], e_ph[2], e_ph[1], e_ph[0],
			e_duty[2], e_duty[1], e_duty[0]};
	endfunction : exp_status

	task automatic note(input logic [7:0] c);
		case (c[7:5])
			OP_DUTY_ONE, OP_DUTY_TWO, OP_DUTY_THREE: e_duty[c[6:5]] = c[4:0];
			OP_CONFIG: {e_rate, e_osc, e_en} = c[4:0];
			OP_PHASE_ONE, OP_PHASE_TWO, OP_PHASE_THREE: e_ph[c[6:5]] = c[1:0];
			default: ;
		endcase
	endtask : note

	// ==========================================================
	// compares, closing and bus tasks
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_count(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
		end
	endtask : check_count

	task automatic close_out();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 24'h0, a, wr, HSIZE_WORD};
		do @(posedge clk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check_word({31'h0, hresp}, 32'h0);
	endtask : ahb

	task automatic cmd(input logic [7:0] c);
		note(c);
		serial_host_model_inst.send({8'h00, c}, 8, 1'b0);
	endtask : cmd

	task automatic status(input int w);
		repeat (w) @(posedge clk);
		ahb(STATUS_OFS, 1'b0, 32'h0);
		check_word({5'h00, rd[26:0]}, exp_status());
	endtask : status

	task automatic measure(input int n);
		{c1, c2, c3} = 24'h0;
		repeat (n) begin
			@(posedge clk);
			c1 += 8'(oe1 === 1'b1);
			c2 += 8'(oe2 === 1'b1);
			c3 += 8'(oe3 === 1'b1);
		end
	endtask : measure

	// hang guard
	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		$display("unexpected at %0t: run timed out", $time);
		close_out();
	end

	// ==========================================================
	// main sequence
	initial begin
		{rst_n, pin_rst_n, hsel, htrans, haddr, hwrite, hsize, hwdata} = '0;
		pin_rst_n = 1'b1;
		{failures, samples_checked} = 0;
		seed = 32'h3F46;
		{e_duty[0], e_duty[1], e_duty[2], e_ph[0], e_ph[1], e_ph[2]} = '0;
		{e_en, e_osc, e_rate} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		status(3);
		ahb(OSC_DIV_OFS, 1'b0, 32'h0);
		check_word(rd, {16'h0, OSC_DIV_RST});
		ahb(8'hFC, 1'b1, 32'hFFFFFFFF);
		ahb(8'hFC, 1'b0, 32'h0);
		check_word(rd, 32'h0);
		ahb(OSC_DIV_OFS, 1'b1, 32'h1);
		for (int i = 0; i < 6; i++) begin
			for (int ch = 0; ch < 3; ch++) begin
				seed = xs(seed);
				cmd({1'b0, 2'(ch), (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : seed[4:0]});
				cmd({1'b1, 2'(ch), seed[9:5]});
			end
			ahb(STATUS_OFS, 1'b0, 32'h0);
			check_word({31'h0, rd[ST_BUSY_BIT]}, 32'h1);
			cmd({3'h3, (i > 3), 4'hF});
			status(150);
			measure(64 << e_rate);
			ex = 8'((e_duty[0] + 1) * (2 << e_rate));
			check_count(c1, ex);
			ex = 8'((e_duty[1] + 1) * (2 << e_rate));
			check_count(c2, ex);
			ex = 8'((e_duty[2] + 1) * (2 << e_rate));
			check_count(c3, ex);
			check_word({29'h0, s1, s2, s3}, 32'h0);
		end
		// only channel one enabled: the enable bits must map to the right pins
		cmd(8'h7C);
		measure(128);
		ex = 8'((e_duty[0] + 1) * 4);
		check_count(c1, ex);
		check_count(c2 + c3, 8'h00);
		note(8'h1F);
		serial_host_model_inst.send({4'h0, 4'hA, 8'h1F}, 12, 1'b0);
		note(8'h2A);
		serial_host_model_inst.send({8'h00, 8'h2A}, 8, 1'b1);
		status(150);
		cmd(8'hE0);
		status(6);
		cmd(8'h67);
		// stopped oscillator: each output keeps the level it had when stopped
		ex = {5'h00, oe1, oe2, oe3};
		measure(100);
		check_count(c1, ex[2] ? 8'h64 : 8'h00);
		check_count(c2, ex[1] ? 8'h64 : 8'h00);
		check_count(c3, ex[0] ? 8'h64 : 8'h00);
		cmd(8'h60);
		measure(20);
		check_count(c1 + c2 + c3, 8'h0);
		cmd(8'h6F);
		pin_rst_n <= 1'b0;
		repeat (60) @(posedge clk);
		pin_rst_n <= 1'b1;
		{e_duty[0], e_duty[1], e_duty[2], e_ph[0], e_ph[1], e_ph[2]} = '0;
		{e_en, e_osc, e_rate} = '0;
		status(5);
		ahb(OSC_DIV_OFS, 1'b0, 32'h0);
		check_word(rd, 32'h1);
		close_out();
	end
endmodule : rgb_pwm_led_controller_bench

`default_nettype wire
